/* core/dsr_accel_fmt.sv */
/*
  Short acceleration response formatter: truncation, zero
  substitution and upper status flags, masked to the response length.
  Assumes length 8 to 15; 8 and 9 are truncated widths.
*/
`timescale 1ns/100ps
module dsr_accel_fmt
  import dsr_pkg::*;
(
  dsr_core_if.fmtEnd fmtIf
);
  logic [7:0]  trunc8;
  logic [8:0]  trunc9;
  logic [15:0] full;

  always_comb begin
    trunc8 = fmtIf.fmtSample[9:2];
    trunc9 = fmtIf.fmtSample[9:1];
    // truncation never yields the error code
    if (trunc8 == 8'h00) begin
      trunc8 = 8'h01;
    end
    if (trunc9 == 9'h000) begin
      trunc9 = 9'h001;
    end
    full = {1'b0, fmtIf.fmtFlags, fmtIf.fmtSample};
    if (fmtIf.fmtLen == SHORT8_LEN) begin
      fmtIf.fmtPayload = {8'h00, trunc8};
    end else if (fmtIf.fmtLen == SHORT9_LEN) begin
      fmtIf.fmtPayload = {7'h00, trunc9};
    end else begin
      fmtIf.fmtPayload = full & dsr_bit_mask(fmtIf.fmtLen);
    end
  end
endmodule // dsr_accel_fmt

/* core/dsr_core_if.sv */
/*
  Carrier between the responder core and its crc and formatter units.
  Assumes all users sit on the same sys_clk.
*/
`timescale 1ns/100ps
interface dsr_core_if;
  logic       crcStart;
  logic       crcStep;
  logic       crcBit;
  logic [7:0] crcSeed;
  logic [7:0] crcPoly;
  logic [3:0] crcWidth;
  logic [7:0] crcValue;
  logic [9:0] fmtSample;
  logic [4:0] fmtLen;
  logic [4:0] fmtFlags;
  logic [15:0] fmtPayload;

  modport crcEnd (input crcStart, crcStep, crcBit, crcSeed, crcPoly, crcWidth, output crcValue);
  modport fmtEnd (input fmtSample, fmtLen, fmtFlags, output fmtPayload);
  modport hub    (output crcStart, crcStep, crcBit, crcSeed, crcPoly, crcWidth,
                  output fmtSample, fmtLen, fmtFlags, input crcValue, fmtPayload);
endinterface // dsr_core_if

/* core/dsr_crc_unit.sv */
/*
  Bit-serial crc of configurable width (0 to 8), msb first.
  Assumes the caller clamps the width and feeds one bit per step.
*/
`timescale 1ns/100ps
module dsr_crc_unit
  import dsr_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  dsr_core_if.crcEnd crcIf
);
  typedef struct packed {
    logic [7:0] crc;
  } dsr_crc_st_t;

  dsr_crc_st_t crc_ff;
  dsr_crc_st_t nxt_crc;
  logic [7:0]  widthMask;
  logic [2:0]  topIdx;
  logic        feedback;

  always_comb begin
    widthMask = dsr_crc_mask(crcIf.crcWidth);
    // width zero wraps here but the mask clears everything
    topIdx    = 3'(crcIf.crcWidth - 4'h1);
    feedback  = crcIf.crcBit ^ crc_ff.crc[topIdx];
    nxt_crc   = crc_ff;
    if (crcIf.crcStart) begin
      nxt_crc.crc = crcIf.crcSeed & widthMask;
    end else if (crcIf.crcStep) begin
      nxt_crc.crc = ({crc_ff.crc[6:0], 1'b0} ^ (feedback ? crcIf.crcPoly : 8'h00)) & widthMask;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      crc_ff <= '0;
    end else begin
      crc_ff <= nxt_crc;
    end
  end

  assign crcIf.crcValue = crc_ff.crc;
endmodule // dsr_crc_unit

/* core/dsr_pkg.sv */
/*
  Shared constants, types and helper functions of the status and
  acceleration responder: command codes, register offsets, field
  positions, reset values and state encoding.
  Assumes a single 200 MHz system clock and an APB register port.
*/
package dsr_pkg;

  // command codes and addressing
  localparam logic [3:0]  CMD_STATUS      = 4'h1;
  localparam logic [3:0]  CMD_ACCEL       = 4'h2;
  localparam logic [3:0]  GLOBAL_ADDR     = 4'h0;

  // response lengths in payload bits, minimum sample code and crc width limit
  localparam logic [4:0]  LONG_LEN        = 5'h10;
  localparam logic [4:0]  SHORT_MIN_LEN   = 5'h08;
  localparam logic [4:0]  SHORT_MAX_LEN   = 5'h0F;
  localparam logic [4:0]  SHORT8_LEN      = 5'h08;
  localparam logic [4:0]  SHORT9_LEN      = 5'h09;
  localparam logic [9:0]  SAMPLE_MIN_CODE = 10'h001;
  localparam logic [3:0]  CRC_W_MAX       = 4'h8;

  // response field positions
  localparam int          RSP_ADDR_LSB    = 12;
  localparam int          ACC_ERR_BIT     = 10;
  localparam int          STS_OTPEN_BIT   = 7;
  localparam int          STS_UV_BIT      = 6;
  localparam int          STS_STEST_BIT   = 5;
  localparam int          STS_BSW_BIT     = 4;
  localparam int          STS_ATTR_LSB    = 2;
  localparam int          STS_ERR_BIT     = 1;

  // register offsets (byte addresses)
  localparam logic [11:0] DEVICE_CONFIG_REG_OFS = 12'h000;
  localparam logic [11:0] CRC_CFG_OFS     = 12'h004;
  localparam logic [11:0] STATUS_OFS      = 12'h008;

  // device_config_reg fields
  localparam int          CFG_ADDR_LSB    = 0;
  localparam int          CFG_ATTR_LSB    = 4;
  localparam int          CFG_BSW_BIT     = 6;
  localparam int          CFG_OTPEN_BIT   = 7;
  localparam int          CFG_CRCW_LSB    = 8;
  localparam logic [11:0] CFG_RST         = 12'h000;
  // crc configuration fields
  localparam int          CRC_POLY_LSB    = 0;
  localparam int          CRC_SEED_LSB    = 8;
  localparam logic [15:0] CRC_CFG_RST     = 16'h0007;
  // status register fields
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_ERR_BIT    = 1;
  localparam int          STAT_STEST_BIT  = 2;
  localparam int          STAT_UV_BIT     = 3;
  localparam int          STAT_CMD_LSB    = 4;
  localparam int          STAT_RSP_LSB    = 16;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CRC  = 3'b010,
    ST_HOLD = 3'b100
  } dsr_state_t;

  // ones in the low len bits
  function automatic logic [15:0] dsr_bit_mask(input logic [4:0] len);
    logic [15:0] m;
    for (int i = 0; i < 16; i++) begin
      m[i] = (5'(i) < len);
    end
    return m;
  endfunction

  // ones in the low w bits of a crc
  function automatic logic [7:0] dsr_crc_mask(input logic [3:0] w);
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      m[i] = (4'(i) < w);
    end
    return m;
  endfunction

endpackage

/* core/dsr_responder.sv */
/*
  Status and acceleration read responder: command decode, address
  filter, response build with snapshot, serial crc and APB registers.
  Assumes the link layer delivers checked commands one at a time and
  drains each response with a valid/ready handshake.
*/
// Behaviour
// - error flag in responses is 1 on internal error, else 0
// - attribute bits in responses copy the configuration attribute field
// - bus switch bit reads 1 when switch commanded closed
// - self-test flag is 1 while self-test runs
// - undervoltage flag set while reservoir voltage below threshold
// - status response carries otp programming enable flag
// - code 0010 requests the current acceleration sample
// - commands with a foreign address are silently ignored
// - no answer while own address is still the global zero
// - command data bits only matter for the command crc check
// - acceleration read accepted in long and short formats
// - long acceleration reply: address, zero, error, 10-bit sample
// - short replies carry sample low, flags above from 11 bits
// - sample is a 10-bit result
// - replies under 10 bits drop sample lsbs
// - truncation to zero sends the minimum code instead
// - sample is offset binary, mid-scale means zero g
// - code 1 is most negative, code 0 means sensor error
// - reply length matches received command length, zero filled
// - code 0001 requests status flags
// - long status reply: address, four zeros, flags, trailing zero
`timescale 1ns/100ps
module dsr_responder
  import dsr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [9:0]  accelSample,
  input  wire logic        internalErrorFlag,
  input  wire logic        selftestActiveFlag,
  input  wire logic        reservoirCapLow,
  output logic             busSwitchState,
  output logic             otpProgramEnableFlag,
  input  wire logic        cmdValid,
  output logic             cmdReady,
  input  wire logic [15:0] cmdWord,
  input  wire logic        cmdLong,
  input  wire logic [4:0]  cmdRspLen,
  input  wire logic        cmdCrcOk,
  output logic             rspValid,
  input  wire logic        rspReady,
  output logic      [15:0] rspData,
  output logic      [4:0]  rspLen,
  output logic      [7:0]  rspCrc,
  output logic      [3:0]  rspCrcLen
);
  typedef struct packed {
    dsr_state_t  state;
    logic [11:0] cfg;
    logic [15:0] crcCfg;
    logic [15:0] payload;
    logic [4:0]  len;
    logic [4:0]  bitCnt;
    logic [3:0]  crcW;
    logic [3:0]  lastCmd;
    logic [31:0] prdata;
    logic        pslverr;
  } dsr_main_t;

  dsr_main_t   core_ff;
  dsr_main_t   nxt_core;
  dsr_core_if  coreIf ();

  logic [3:0]  assignedDeviceAddress;
  logic [1:0]  attributeBits;
  logic [3:0]  cmdCode;
  logic [3:0]  cmdAddr;
  logic        lenOk;
  logic        cmdHit;
  logic [4:0]  hitLen;
  logic [7:0]  statusLow;
  logic [3:0]  crcWidthCfg;
  logic        apbWrite;

  dsr_crc_unit u_crc (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .crcIf   (coreIf.crcEnd)
  );

  dsr_accel_fmt u_fmt (
    .fmtIf (coreIf.fmtEnd)
  );

  // configuration fields
  assign assignedDeviceAddress = core_ff.cfg[CFG_ADDR_LSB +: 4];
  assign attributeBits         = core_ff.cfg[CFG_ATTR_LSB +: 2];
  assign busSwitchState        = core_ff.cfg[CFG_BSW_BIT];
  assign otpProgramEnableFlag  = core_ff.cfg[CFG_OTPEN_BIT];
  assign crcWidthCfg = (core_ff.cfg[CFG_CRCW_LSB +: 4] > CRC_W_MAX) ? CRC_W_MAX
                                                                      : core_ff.cfg[CFG_CRCW_LSB +: 4];

  // command decode; data bits D[7:0] reach only the link crc check
  assign cmdCode  = cmdWord[3:0];
  assign cmdAddr  = cmdWord[7:4];
  assign cmdReady = (core_ff.state == ST_IDLE);
  assign lenOk    = cmdLong || (cmdRspLen >= SHORT_MIN_LEN && cmdRspLen <= SHORT_MAX_LEN);
  assign hitLen   = cmdLong ? LONG_LEN : cmdRspLen;
  assign cmdHit   = cmdValid && cmdReady && cmdCrcOk && lenOk
                    && (cmdAddr == assignedDeviceAddress)
                    && (assignedDeviceAddress != GLOBAL_ADDR)
                    && (cmdCode == CMD_STATUS || cmdCode == CMD_ACCEL);

  // status flag byte, shared by long and short status replies
  always_comb begin
    statusLow                   = 8'h00;
    statusLow[STS_OTPEN_BIT]    = otpProgramEnableFlag;
    statusLow[STS_UV_BIT]       = reservoirCapLow;
    statusLow[STS_STEST_BIT]    = selftestActiveFlag;
    statusLow[STS_BSW_BIT]      = busSwitchState;
    statusLow[STS_ATTR_LSB +: 2] = attributeBits;
    statusLow[STS_ERR_BIT]      = internalErrorFlag;
  end

  // short acceleration formatter and crc feed
  assign coreIf.fmtSample = accelSample;
  assign coreIf.fmtLen    = cmdRspLen;
  assign coreIf.fmtFlags  = {attributeBits, selftestActiveFlag, reservoirCapLow, internalErrorFlag};
  assign coreIf.crcStart  = cmdHit;
  assign coreIf.crcStep   = (core_ff.state == ST_CRC);
  assign coreIf.crcBit    = core_ff.payload[4'(core_ff.bitCnt - 5'h01)];
  assign coreIf.crcSeed   = core_ff.crcCfg[CRC_SEED_LSB +: 8];
  assign coreIf.crcPoly   = core_ff.crcCfg[CRC_POLY_LSB +: 8];
  // seed is masked with the width of the command being taken, not the last one
  assign coreIf.crcWidth  = (core_ff.state == ST_IDLE) ? crcWidthCfg : core_ff.crcW;

  assign apbWrite = psel && penable && pwrite;

  always_comb begin
    nxt_core = core_ff;
    // read data and error are prepared in the setup cycle
    if (psel && !penable) begin
      nxt_core.prdata  = 32'h0000_0000;
      nxt_core.pslverr = 1'b0;
      if (paddr == DEVICE_CONFIG_REG_OFS) begin
        nxt_core.prdata[11:0] = core_ff.cfg;
      end else if (paddr == CRC_CFG_OFS) begin
        nxt_core.prdata[15:0] = core_ff.crcCfg;
      end else if (paddr == STATUS_OFS) begin
        nxt_core.pslverr                     = pwrite;
        nxt_core.prdata[STAT_BUSY_BIT]       = (core_ff.state != ST_IDLE);
        nxt_core.prdata[STAT_ERR_BIT]        = internalErrorFlag;
        nxt_core.prdata[STAT_STEST_BIT]      = selftestActiveFlag;
        nxt_core.prdata[STAT_UV_BIT]         = reservoirCapLow;
        nxt_core.prdata[STAT_CMD_LSB +: 4]   = core_ff.lastCmd;
        nxt_core.prdata[STAT_RSP_LSB +: 16]  = core_ff.payload;
      end else begin
        nxt_core.pslverr = 1'b1;
      end
    end
    if (apbWrite && paddr == DEVICE_CONFIG_REG_OFS) begin
      nxt_core.cfg = pwdata[11:0];
    end
    if (apbWrite && paddr == CRC_CFG_OFS) begin
      nxt_core.crcCfg = pwdata[15:0];
    end

    unique case (core_ff.state)
      ST_IDLE: begin
        if (cmdHit) begin
          // snapshot of sample and flags for the whole reply
          nxt_core.len     = hitLen;
          nxt_core.bitCnt  = hitLen;
          nxt_core.crcW    = crcWidthCfg;
          nxt_core.lastCmd = cmdCode;
          nxt_core.state   = ST_CRC;
          if (cmdCode == CMD_STATUS && cmdLong) begin
            nxt_core.payload = {assignedDeviceAddress, 4'h0, statusLow};
          end else if (cmdCode == CMD_STATUS) begin
            nxt_core.payload = {8'h00, statusLow};
          end else if (cmdLong) begin
            nxt_core.payload = {assignedDeviceAddress, 1'b0, internalErrorFlag, accelSample};
          end else begin
            nxt_core.payload = coreIf.fmtPayload;
          end
        end
      end
      ST_CRC: begin
        nxt_core.bitCnt = core_ff.bitCnt - 5'h01;
        if (core_ff.bitCnt == 5'h01) begin
          nxt_core.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (rspReady) begin
          nxt_core.state = ST_IDLE;
        end
      end
      default: begin
        nxt_core.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      core_ff         <= '0;
      core_ff.state   <= ST_IDLE;
      core_ff.cfg     <= CFG_RST;
      core_ff.crcCfg  <= CRC_CFG_RST;
    end else begin
      core_ff <= nxt_core;
    end
  end

  assign pready    = psel && penable;
  assign prdata    = core_ff.prdata;
  assign pslverr   = core_ff.pslverr && psel && penable;
  assign rspValid  = (core_ff.state == ST_HOLD);
  assign rspData   = core_ff.payload;
  assign rspLen    = core_ff.len;
  assign rspCrc    = coreIf.crcValue;
  assign rspCrcLen = core_ff.crcW;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic hitStatus;
  logic hitAccel;
  assign hitStatus = cmdHit && cmdCode == CMD_STATUS;
  assign hitAccel  = cmdHit && cmdCode == CMD_ACCEL;

  global_ignore_a: assert property (cmdValid && cmdReady && assignedDeviceAddress == GLOBAL_ADDR
      |=> core_ff.state == ST_IDLE [*2]) else $error("answered while address is global");
  foreign_addr_a: assert property (cmdValid && cmdReady && cmdAddr != assignedDeviceAddress
      |=> !rspValid ##1 core_ff.state == ST_IDLE) else $error("answered a foreign address");
  accel_code_a: assert property (cmdValid && cmdReady && cmdCrcOk && lenOk && cmdCode == CMD_ACCEL
      && cmdAddr == assignedDeviceAddress && cmdAddr != GLOBAL_ADDR |=> core_ff.state == ST_CRC)
      else $error("acceleration read not accepted");
  long_accel_a: assert property (hitAccel && cmdLong |=> core_ff.payload[9:0] == $past(accelSample)
      && core_ff.payload[ACC_ERR_BIT] == $past(internalErrorFlag) && core_ff.payload[11] == 1'b0
      && core_ff.payload[15:12] == $past(cmdAddr)) else $error("long acceleration layout wrong");
  long_status_a: assert property (hitStatus && cmdLong |=> core_ff.payload[11:8] == 4'h0
      && core_ff.payload[0] == 1'b0 && core_ff.payload[15:12] == $past(cmdAddr))
      else $error("long status layout wrong");
  err_flag_a: assert property (hitStatus |=> core_ff.payload[STS_ERR_BIT] == $past(internalErrorFlag))
      else $error("status error flag wrong");
  attr_bits_a: assert property (hitStatus |=> core_ff.payload[STS_ATTR_LSB +: 2]
      == $past(core_ff.cfg[CFG_ATTR_LSB +: 2])) else $error("attribute bits wrong");
  bus_switch_a: assert property (hitStatus |=> core_ff.payload[STS_BSW_BIT] == $past(busSwitchState))
      else $error("bus switch bit wrong");
  selftest_flag_a: assert property (hitStatus |=> core_ff.payload[STS_STEST_BIT] == $past(selftestActiveFlag))
      else $error("self-test flag wrong");
  uv_flag_a: assert property (hitStatus |=> core_ff.payload[STS_UV_BIT] == $past(reservoirCapLow))
      else $error("undervoltage flag wrong");
  otp_flag_a: assert property (hitStatus |=> core_ff.payload[STS_OTPEN_BIT] == $past(otpProgramEnableFlag))
      else $error("otp enable flag wrong");
  trunc_min_a: assert property (hitAccel && !cmdLong && cmdRspLen == SHORT8_LEN
      |=> core_ff.payload[15:8] == 8'h00 && core_ff.payload[7:0] != 8'h00) else $error("zero after truncation");
  trunc9_a: assert property (hitAccel && !cmdLong && cmdRspLen == SHORT9_LEN && accelSample[9:1] != 9'h000
      |=> core_ff.payload == {7'h00, $past(accelSample[9:1])}) else $error("9-bit truncation wrong");
  short_mask_a: assert property (cmdHit && !cmdLong |=> (core_ff.payload & ~dsr_bit_mask(core_ff.len))
      == 16'h0000 && core_ff.len == $past(cmdRspLen)) else $error("reply wider than command");
  crc_time_a: assert property (cmdHit |-> ##[2:17] rspValid) else $error("reply not ready in time");
  crc_zero_a: assert property (rspValid && rspCrcLen == 4'h0 |-> rspCrc == 8'h00)
      else $error("crc bits beyond width");
  hold_stable_a: assert property (rspValid && !rspReady |=> rspValid && $stable(rspData)
      && $stable(rspCrc) && $stable(rspLen)) else $error("reply changed while held");

  status_long_c: cover property (hitStatus && cmdLong ##[1:17] rspValid && rspReady);
  accel_short8_c: cover property (hitAccel && cmdRspLen == SHORT8_LEN && accelSample[9:2] == 8'h00);
  accel_long_c: cover property (hitAccel && cmdLong ##[1:17] rspValid);
  global_drop_c: cover property (cmdValid && cmdReady && assignedDeviceAddress == GLOBAL_ADDR);
endmodule // dsr_responder

/* dv/dsr_accel_status_responder_tb_top.sv */
/*
  Testbench of the responder: register access, status and acceleration
  replies, ignored commands, snapshot and crc.
  Assumes the bus master model dsr_master_model.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin fails++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module dsr_accel_status_responder_tb_top
  import dsr_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        nrst, psel, penable, pwrite, pready, pslverr, got, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  accelSample;
  logic        internalErrorFlag, selftestActiveFlag, reservoirCapLow, busSwitchState, otpProgramEnableFlag;
  logic        cmdValid, cmdReady, cmdLong, cmdCrcOk, rspValid, rspReady;
  logic [15:0] cmdWord, rspData, ex;
  logic [4:0]  cmdRspLen, rspLen;
  logic [7:0]  rspCrc;
  logic [3:0]  rspCrcLen;
  logic [32:0] rsp;
  int          fails = 0;
  int          nCompared = 0;

  always #2.5 sys_clk = ~sys_clk;

  dsr_responder DUT (.sys_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .accelSample, .internalErrorFlag, .selftestActiveFlag, .reservoirCapLow, .busSwitchState,
    .otpProgramEnableFlag, .cmdValid, .cmdReady, .cmdWord, .cmdLong, .cmdRspLen, .cmdCrcOk,
    .rspValid, .rspReady, .rspData, .rspLen, .rspCrc, .rspCrcLen);
  dsr_master_model M (.sys_clk, .cmdValid, .cmdReady, .cmdWord, .cmdLong, .cmdRspLen, .cmdCrcOk,
    .rspValid, .rspReady, .rspData, .rspLen, .rspCrc, .rspCrcLen);

  function automatic logic [15:0] expSts();
    return {4'h5, 4'h0, 1'b1, reservoirCapLow, selftestActiveFlag, 1'b1, 2'b10, internalErrorFlag, 1'b0};
  endfunction

  function automatic logic [15:0] expAcc(input int len, input logic [9:0] s);
    logic [15:0] v;
    v = {1'b0, 2'b10, selftestActiveFlag, reservoirCapLow, internalErrorFlag, s};
    if (len == 8) v = (s[9:2] == 8'h00) ? 16'h0001 : {8'h00, s[9:2]};
    else if (len == 9) v = (s[9:1] == 9'h000) ? 16'h0001 : {7'h00, s[9:1]};
    return v & 16'((32'h1 << len) - 1);
  endfunction

  function automatic logic [7:0] crcOf(input logic [15:0] p, input int len, input int w, input logic [7:0] poly,
                                       input logic [7:0] seed);
    logic [7:0] m, c;
    m = 8'((32'h1 << w) - 1);
    c = seed & m;
    for (int i = len - 1; i >= 0; i--) begin
      c = ((c << 1) ^ ((p[i] ^ c[w - 1]) ? poly : 8'h00)) & m;
    end
    return c;
  endfunction

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fails++;
      wrap_up();
    end
    @(posedge sys_clk);
  endtask

  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {internalErrorFlag, selftestActiveFlag, reservoirCapLow} = 3'b111;
    accelSample = 10'h3FD;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    apb(0, DEVICE_CONFIG_REG_OFS, 32'h00000000);
    `CHK(rd, 32'h00000000)
    apb(0, CRC_CFG_OFS, 32'h00000000);
    `CHK(rd, 32'h00000007)
    apb(0, 12'h010, 32'h00000000);
    `CHK(err, 1'b1)
    apb(1, STATUS_OFS, 32'hFFFFFFFF);
    `CHK(err, 1'b1)
    for (int i = 1; i < 3; i++) begin
      M.xfer(16'(i), 1, 5'h10, 1, 0, got, rsp);
      `CHK(got, 1'b0)
    end
    $display("test reset done");
    apb(1, DEVICE_CONFIG_REG_OFS, 32'h000000E5);
    `CHK(busSwitchState, 1'b1)
    `CHK(otpProgramEnableFlag, 1'b1)
    for (int i = 0; i < 8; i++) begin
      {internalErrorFlag, selftestActiveFlag, reservoirCapLow} <= 3'(i);
      M.xfer(16'h0051, 1, 5'h08, 1, i % 3, got, rsp);
      `CHK(rsp[32:12], {expSts(), 5'h10})
      `CHK(rsp[11:0], 12'h000)
      M.xfer(16'hA551, 0, 5'h08, 1, 0, got, rsp);
      `CHK(rsp[32:12], {8'h00, 8'(expSts()), 5'h08})
    end
    $display("test status done");
    for (int i = 0; i < 5; i++) begin
      M.xfer(i == 0 ? 16'h0061 : i == 1 ? 16'h0053 : i == 2 ? 16'h0054 : 16'h0052, i != 4, 5'h10, i != 3, 0, got, rsp);
      `CHK(got, 1'b0)
    end
    $display("test ignore done");
    accelSample <= 10'h201;
    M.xfer(16'h0052, 1, 5'h08, 1, 0, got, rsp);
    `CHK(rsp[32:17], {4'h5, 1'b0, internalErrorFlag, 10'h201})
    accelSample <= 10'h000;
    M.xfer(16'h0052, 1, 5'h08, 1, 0, got, rsp);
    `CHK(rsp[32:17], {4'h5, 1'b0, internalErrorFlag, 10'h000})
    accelSample <= 10'h3FD;
    for (int len = 8; len < 16; len++) begin
      M.xfer(16'h0052, 0, 5'(len), 1, 1, got, rsp);
      `CHK(rsp[32:17], expAcc(len, 10'h3FD))
      `CHK(rsp[16:12], 5'(len))
    end
    for (int len = 8; len < 10; len++) begin
      accelSample <= (len == 8) ? 10'h003 : 10'h001;
      M.xfer(16'h0052, 0, 5'(len), 1, 0, got, rsp);
      `CHK(rsp[32:17], 16'h0001)
    end
    $display("test accel done");
    accelSample <= 10'h2AA;
    @(posedge sys_clk);
    ex = {4'h5, 1'b0, internalErrorFlag, 10'h2AA};
    fork
      M.xfer(16'h0052, 1, 5'h08, 1, 4, got, rsp);
      begin
        repeat (6) @(posedge sys_clk);
        accelSample <= 10'h155;
        internalErrorFlag <= ~internalErrorFlag;
      end
    join
    `CHK(rsp[32:17], ex)
    $display("test snapshot done");
    for (int j = 0; j < 2; j++) begin
      apb(1, CRC_CFG_OFS, j == 0 ? 32'h0000A507 : 32'h00000007);
      apb(1, DEVICE_CONFIG_REG_OFS, j == 0 ? 32'h000008E5 : 32'h000003E5);
      M.xfer(16'h0051, j == 0, 5'h08, 1, 0, got, rsp);
      ex = (j == 0) ? expSts() : {8'h00, 8'(expSts())};
      `CHK(rsp[11:4], crcOf(ex, j == 0 ? 16 : 8, j == 0 ? 8 : 3, 8'h07, j == 0 ? 8'hA5 : 8'h00))
      `CHK(rsp[3:0], j == 0 ? 4'h8 : 4'h3)
    end
    apb(0, STATUS_OFS, 32'h00000000);
    ex = {8'h00, 8'(expSts())};
    `CHK(rd, {ex, 8'h00, CMD_STATUS, reservoirCapLow, selftestActiveFlag, internalErrorFlag, 1'b0})
    $display("test crc done");
    wrap_up();
  end
endmodule // dsr_accel_status_responder_tb_top

/* dv/dsr_master_model.sv */
/*
  Bus master model: issues checked commands and drains the replies.
  Assumes the responder runs on the same sys_clk as this model.
*/
`timescale 1ns/100ps
module dsr_master_model (
  input  wire logic        sys_clk,
  output logic             cmdValid,
  input  wire logic        cmdReady,
  output logic      [15:0] cmdWord,
  output logic             cmdLong,
  output logic      [4:0]  cmdRspLen,
  output logic             cmdCrcOk,
  input  wire logic        rspValid,
  output logic             rspReady,
  input  wire logic [15:0] rspData,
  input  wire logic [4:0]  rspLen,
  input  wire logic [7:0]  rspCrc,
  input  wire logic [3:0]  rspCrcLen
);
  initial begin
    cmdValid  = 1'b0;
    cmdWord   = 16'h0000;
    cmdLong   = 1'b0;
    cmdRspLen = 5'h08;
    cmdCrcOk  = 1'b0;
    rspReady  = 1'b0;
  end

  // one command, then the reply taken after stall cycles; got is x if the command is never accepted, 0 if no reply comes
  task automatic xfer(input logic [15:0] w, input logic lng, input logic [4:0] len, input logic ok,
                      input int stall, output logic got, output logic [32:0] rsp);
    int n;
    got = 1'bx;
    rsp = '0;
    @(posedge sys_clk);
    cmdValid  <= 1'b1;
    cmdWord   <= w;
    cmdLong   <= lng;
    cmdRspLen <= len;
    cmdCrcOk  <= ok;
    for (n = 0; n < 20; n++) begin
      @(negedge sys_clk);
      if (cmdReady === 1'b1) break;
    end
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    cmdWord  <= ~w;
    if (n == 20) return;
    got = 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (rspValid === 1'b1) break;
    end
    if (n == 40) return;
    repeat (stall) @(posedge sys_clk);
    rspReady <= 1'b1;
    // reply taken at the edge that sees ready high
    @(posedge sys_clk);
    got = rspValid;
    rsp = {rspData, rspLen, rspCrc, rspCrcLen};
    rspReady <= 1'b0;
  endtask
endmodule // dsr_master_model
